// ---- logic/ptc_bit_voter.sv ----
// Sample clock prescaler and majority-vote bit decoder
`timescale 1ns/1ps
module ptc_bit_voter (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk_en,
    input wire logic [1:0] period_sel,
    input wire logic [1:0] strobe_sel,
    input wire logic rx_line,
    output logic bit_r,
    output logic bit_valid_r
);
    logic [1:0] div_r;
    logic [1:0] div_last;
    logic tick;
    logic [2:0] samp_r;
    logic [6:0] hist_r;
    logic [7:0] win;
    logic [2:0] vote_n;
    logic [2:0] ones;
    logic [3:0] idle_r;

    // Prescaler: a sample every 1, 2 or 4 sample-clock enables
    always_comb begin
        case (period_sel)
            2'b00: div_last = 2'h0;
            2'b01: div_last = 2'h1;
            default: div_last = 2'h3;
        endcase
    end
    assign tick = sclk_en && (div_r >= div_last);

    always_ff @(posedge clk) begin
        if (rst) begin
            div_r <= 2'h0;
        end else if (sclk_en) begin
            div_r <= (div_r >= div_last) ? 2'h0 : div_r + 2'h1;
        end
    end

    // Vote width from the strobe field
    always_comb begin
        case (strobe_sel)
            2'b01: vote_n = ptc_pkg::VOTE_N_SHORT;
            2'b10: vote_n = ptc_pkg::VOTE_N_LONG;
            default: vote_n = ptc_pkg::VOTE_N_DEFAULT;
        endcase
    end

    // Count ones among the newest samples of the window
    assign win = {hist_r, rx_line};
    always_comb begin
        ones = 3'h0;
        for (int k = 0; k < 8; k++) begin
            if (3'(k) < vote_n && win[k]) begin
                ones = ones + 3'h1;
            end
        end
    end

    // Eight samples make a bit whatever the prescaler says
    always_ff @(posedge clk) begin
        if (rst) begin
            samp_r <= 3'h0;
            hist_r <= 7'h7f;
            bit_r <= 1'b1;
            bit_valid_r <= 1'b0;
        end else begin
            bit_valid_r <= 1'b0;
            if (tick) begin
                hist_r <= win[6:0];
                samp_r <= samp_r + 3'h1;
                if (samp_r == ptc_pkg::SAMPLES_PER_BIT) begin
                    // Ties of an even vote resolve low, a dominant bus wins
                    bit_r <= ({1'b0, ones, 1'b0} > {2'b00, vote_n});
                    bit_valid_r <= 1'b1;
                end
            end
        end
    end

    // Helper: ticks since the last decided bit
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_r <= 4'h0;
        end else if (bit_valid_r) begin
            idle_r <= tick ? 4'h1 : 4'h0;
        end else if (tick && idle_r != 4'hf) begin
            idle_r <= idle_r + 4'h1;
        end
    end

    // Every decided bit, the first after reset too, must follow exactly eight ticks
    AST_EIGHT_SAMPLES: assert property (@(posedge clk) disable iff (rst)
        bit_valid_r |-> idle_r == 4'h8)
        else $error("bit decided after wrong number of samples");
endmodule : ptc_bit_voter

// ---- logic/ptc_cfg_reg.sv ----
// One configuration word with write mask and forced bits
`timescale 1ns/1ps
module ptc_cfg_reg #(
    parameter logic [31:0] RESET_VAL = 32'h00000000,
    parameter logic [31:0] WR_MASK = 32'hffffffff,
    parameter logic [31:0] FORCE_ONE = 32'h00000000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    output logic [31:0] q_r
);
    // Unwritable bits read as zero, forced bits stay one
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= RESET_VAL;
        end else if (wr_en) begin
            q_r <= (wdata & WR_MASK) | FORCE_ONE;
        end
    end
endmodule : ptc_cfg_reg

// ---- logic/ptc_pkg.sv ----
// Package with register map, field layout, reset values and decode constants for the bank
// What this block does
// - Configuration writes accepted only in configuration states
// - Wakeup repeat count at bits 31:26
// - Wakeup receive window at bits 24:16
// - Every bit period takes eight samples
// - Prescaler selects sample period and microtick samples
// - Majority vote over four, five or six samples
// - Collision symbol limit, top bit forced one
// - Start sequence length at bits 3:0
// - Wakeup transmit low and idle times
// - Wakeup receive low and idle limits
// - Latest dynamic minislot; zero disables dynamic sending
// - Static payload bytes are twice field value
// - Microticks per cycle field
// - Sync sender limit at bits 19:16
// - Macroticks per cycle at bits 13:0
// - Per-channel macrotick initial offsets
// - Per-channel microtick initial offsets
// - Offset correction start minus one
// - Idle time starts at matching macrotick
package ptc_pkg;
    localparam int NUM_CFG = 7;
    // Byte offsets of the bank on the register bus
    localparam logic [7:0] OFS_CODING_CFG1 = 8'h00;
    localparam logic [7:0] OFS_WAKEUP_CFG2 = 8'h04;
    localparam logic [7:0] OFS_MSG_CFG = 8'h08;
    localparam logic [7:0] OFS_GTIME_CFG1 = 8'h0c;
    localparam logic [7:0] OFS_GTIME_CFG2 = 8'h10;
    localparam logic [7:0] OFS_GTIME_CFG3 = 8'h14;
    localparam logic [7:0] OFS_GTIME_CFG4 = 8'h18;
    localparam logic [7:0] OFS_BANK_STATUS = 8'h1c;
    localparam logic [2:0] IDX_STATUS = 3'h7;
    // Status register bits
    localparam int ST_CFG_OPEN = 0;
    localparam int ST_WR_REFUSED = 1;
    // Protocol state codes seen on the state input
    localparam logic [3:0] POC_DEFAULT_CONFIG = 4'h0;
    localparam logic [3:0] POC_CONFIG = 4'h1;
    // Writable bits of each register
    localparam logic [31:0] REG_MASK [0:NUM_CFG-1] = '{
        32'hfdfff7ff, 32'h3fff3f3f, 32'h1fff007f, 32'h000fffff,
        32'h000f3fff, 32'h7f7fffff, 32'h3fff3fff};
    // Bits held at one whatever is written
    localparam logic [31:0] REG_FORCE [0:NUM_CFG-1] = '{
        32'h00000400, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000000, 32'h00000000, 32'h00000000};
    localparam logic [31:0] REG_RESET [0:NUM_CFG-1] = '{
        32'h00000400, 32'h00000000, 32'h00000000, 32'h00000000,
        32'h00000002, 32'h00000002, 32'h00000000};
    // Field positions
    localparam int F_RPT_LSB = 26;
    localparam int F_RXWIN_LSB = 16;
    localparam int F_BRP_LSB = 14;
    localparam int F_SPP_LSB = 12;
    localparam int F_CASM_LSB = 4;
    localparam int F_TSS_LSB = 0;
    localparam int F_TXL_LSB = 24;
    localparam int F_TXI_LSB = 16;
    localparam int F_RXL_LSB = 8;
    localparam int F_RXI_LSB = 0;
    localparam int F_SLT_LSB = 16;
    localparam int F_SFDL_LSB = 0;
    localparam int F_UT_LSB = 0;
    localparam int F_SNM_LSB = 16;
    localparam int F_MPC_LSB = 0;
    localparam int F_MIOB_LSB = 24;
    localparam int F_MIOA_LSB = 16;
    localparam int F_UIOB_LSB = 8;
    localparam int F_UIOA_LSB = 0;
    localparam int F_OCS_LSB = 16;
    localparam int F_NIT_LSB = 0;
    // Bit decoding constants
    localparam logic [2:0] SAMPLES_PER_BIT = 3'h7;
    localparam logic [2:0] VOTE_N_DEFAULT = 3'h5;
    localparam logic [2:0] VOTE_N_SHORT = 3'h4;
    localparam logic [2:0] VOTE_N_LONG = 3'h6;
    localparam logic [2:0] PERIOD_ONE = 3'h1;
    localparam logic [2:0] PERIOD_TWO = 3'h2;
    localparam logic [2:0] PERIOD_FOUR = 3'h4;
endpackage : ptc_pkg

// ---- logic/ptc_timing_bank.sv ----
// Protocol timing configuration bank with APB access and bit decoder
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module ptc_timing_bank (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [3:0] POC_STATE,
    input wire logic SCLK_EN,
    input wire logic RX_LINE,
    input wire logic MT_TICK,
    input wire logic [13:0] MT_COUNT,
    output logic [5:0] WAKEUP_REPEAT_COUNT,
    output logic [8:0] WAKEUP_RX_WINDOW,
    output logic [1:0] BAUD_PRESCALE_SEL,
    output logic [1:0] STROBE_SAMPLE_COUNT,
    output logic [6:0] COLLISION_SYMBOL_MAX,
    output logic [3:0] START_SEQUENCE_LENGTH,
    output logic [5:0] WAKEUP_TX_LOW_TIME,
    output logic [7:0] WAKEUP_TX_IDLE_TIME,
    output logic [5:0] WAKEUP_RX_LOW_TIME,
    output logic [5:0] WAKEUP_RX_IDLE_TIME,
    output logic [12:0] LATEST_DYNAMIC_TX_MINISLOT,
    output logic [6:0] STATIC_PAYLOAD_WORDS,
    output logic [19:0] CYCLE_MICROTICK_TOTAL,
    output logic [3:0] SYNC_SENDER_LIMIT,
    output logic [13:0] CYCLE_MACROTICK_TOTAL,
    output logic [6:0] MACRO_INITIAL_OFFSET_B,
    output logic [6:0] MACRO_INITIAL_OFFSET_A,
    output logic [7:0] MICRO_INITIAL_OFFSET_B,
    output logic [7:0] MICRO_INITIAL_OFFSET_A,
    output logic [13:0] OFFSET_CORRECTION_BEGIN,
    output logic [13:0] IDLE_TIME_BEGIN,
    output logic [2:0] SAMPLE_PERIOD,
    output logic [1:0] SAMPLES_PER_MICROTICK,
    output logic [2:0] VOTE_SAMPLES,
    output logic DYN_TX_ENABLE,
    output logic [7:0] STATIC_PAYLOAD_BYTES,
    output logic IDLE_TIME_START,
    output logic OFFSET_CORR_START,
    output logic RX_BIT,
    output logic RX_BIT_VALID
);
    logic [31:0] cfg_q [0:ptc_pkg::NUM_CFG-1];
    logic [31:0] rd_mux;
    logic [2:0] idx;
    logic addr_ok;
    logic is_cfg;
    logic cfg_open;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic refused_r;
    logic access_start;
    logic wr_commit;
    logic cfg_wr_ok;
    logic [13:0] ocs_pos;

    // Word decode: eight aligned words from offset zero
    assign idx = PADDR[4:2];
    assign addr_ok = (PADDR[7:5] == 3'h0) && (PADDR[1:0] == 2'h0);
    assign is_cfg = addr_ok && (idx != ptc_pkg::IDX_STATUS);
    assign cfg_open = (POC_STATE == ptc_pkg::POC_DEFAULT_CONFIG)
        || (POC_STATE == ptc_pkg::POC_CONFIG);
    assign access_start = PSEL && PENABLE && !pready_r;
    assign wr_commit = PSEL && PENABLE && pready_r && PWRITE;
    assign cfg_wr_ok = wr_commit && is_cfg && cfg_open;

    // The seven configuration words share one register module
    genvar gi;
    generate
        for (gi = 0; gi < ptc_pkg::NUM_CFG; gi++) begin : g_cfg
            ptc_cfg_reg #(
                .RESET_VAL(ptc_pkg::REG_RESET[gi]),
                .WR_MASK(ptc_pkg::REG_MASK[gi]),
                .FORCE_ONE(ptc_pkg::REG_FORCE[gi])
            ) u_reg (
                .clk(CLK),
                .rst(RST),
                .wr_en(cfg_wr_ok && (idx == 3'(gi))),
                .wdata(PWDATA),
                .q_r(cfg_q[gi])
            );
        end
    endgenerate

    // Read mux: stored words stay readable in every state
    always_comb begin
        case (idx)
            3'h0: rd_mux = cfg_q[0];
            3'h1: rd_mux = cfg_q[1];
            3'h2: rd_mux = cfg_q[2];
            3'h3: rd_mux = cfg_q[3];
            3'h4: rd_mux = cfg_q[4];
            3'h5: rd_mux = cfg_q[5];
            3'h6: rd_mux = cfg_q[6];
            default: begin
                rd_mux = 32'h00000000;
                rd_mux[ptc_pkg::ST_CFG_OPEN] = cfg_open;
                rd_mux[ptc_pkg::ST_WR_REFUSED] = refused_r;
            end
        endcase
    end

    // APB slave: one wait state, so data and error are registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (access_start) begin
            pready_r <= 1'b1;
            prdata_r <= (!PWRITE && addr_ok) ? rd_mux : 32'h00000000;
            pslverr_r <= !addr_ok || (PWRITE && is_cfg && !cfg_open);
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
    end
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign PRDATA = prdata_r;

    // Sticky refused-write flag; a new refusal beats a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            refused_r <= 1'b0;
        end else if (wr_commit && is_cfg && !cfg_open) begin
            refused_r <= 1'b1;
        end else if (wr_commit && addr_ok && idx == ptc_pkg::IDX_STATUS
                     && PWDATA[ptc_pkg::ST_WR_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Field views of the stored words
    assign WAKEUP_REPEAT_COUNT = cfg_q[0][ptc_pkg::F_RPT_LSB +: 6];
    assign WAKEUP_RX_WINDOW = cfg_q[0][ptc_pkg::F_RXWIN_LSB +: 9];
    assign BAUD_PRESCALE_SEL = cfg_q[0][ptc_pkg::F_BRP_LSB +: 2];
    assign STROBE_SAMPLE_COUNT = cfg_q[0][ptc_pkg::F_SPP_LSB +: 2];
    assign COLLISION_SYMBOL_MAX = cfg_q[0][ptc_pkg::F_CASM_LSB +: 7];
    assign START_SEQUENCE_LENGTH = cfg_q[0][ptc_pkg::F_TSS_LSB +: 4];
    assign WAKEUP_TX_LOW_TIME = cfg_q[1][ptc_pkg::F_TXL_LSB +: 6];
    assign WAKEUP_TX_IDLE_TIME = cfg_q[1][ptc_pkg::F_TXI_LSB +: 8];
    assign WAKEUP_RX_LOW_TIME = cfg_q[1][ptc_pkg::F_RXL_LSB +: 6];
    assign WAKEUP_RX_IDLE_TIME = cfg_q[1][ptc_pkg::F_RXI_LSB +: 6];
    assign LATEST_DYNAMIC_TX_MINISLOT = cfg_q[2][ptc_pkg::F_SLT_LSB +: 13];
    assign STATIC_PAYLOAD_WORDS = cfg_q[2][ptc_pkg::F_SFDL_LSB +: 7];
    assign CYCLE_MICROTICK_TOTAL = cfg_q[3][ptc_pkg::F_UT_LSB +: 20];
    assign SYNC_SENDER_LIMIT = cfg_q[4][ptc_pkg::F_SNM_LSB +: 4];
    assign CYCLE_MACROTICK_TOTAL = cfg_q[4][ptc_pkg::F_MPC_LSB +: 14];
    assign MACRO_INITIAL_OFFSET_B = cfg_q[5][ptc_pkg::F_MIOB_LSB +: 7];
    assign MACRO_INITIAL_OFFSET_A = cfg_q[5][ptc_pkg::F_MIOA_LSB +: 7];
    assign MICRO_INITIAL_OFFSET_B = cfg_q[5][ptc_pkg::F_UIOB_LSB +: 8];
    assign MICRO_INITIAL_OFFSET_A = cfg_q[5][ptc_pkg::F_UIOA_LSB +: 8];
    assign OFFSET_CORRECTION_BEGIN = cfg_q[6][ptc_pkg::F_OCS_LSB +: 14];
    assign IDLE_TIME_BEGIN = cfg_q[6][ptc_pkg::F_NIT_LSB +: 14];

    // The field holds the position minus one, so the start is one macrotick later
    assign ocs_pos = OFFSET_CORRECTION_BEGIN + 14'h0001;

    // Decoded timing values for the protocol engine, registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            SAMPLE_PERIOD <= ptc_pkg::PERIOD_ONE;
            SAMPLES_PER_MICROTICK <= 2'h2;
            VOTE_SAMPLES <= ptc_pkg::VOTE_N_DEFAULT;
            DYN_TX_ENABLE <= 1'b0;
            STATIC_PAYLOAD_BYTES <= 8'h00;
        end else begin
            case (BAUD_PRESCALE_SEL)
                2'b00: begin
                    SAMPLE_PERIOD <= ptc_pkg::PERIOD_ONE;
                    SAMPLES_PER_MICROTICK <= 2'h2;
                end
                2'b01: begin
                    SAMPLE_PERIOD <= ptc_pkg::PERIOD_TWO;
                    SAMPLES_PER_MICROTICK <= 2'h1;
                end
                default: begin
                    SAMPLE_PERIOD <= ptc_pkg::PERIOD_FOUR;
                    SAMPLES_PER_MICROTICK <= 2'h1;
                end
            endcase
            case (STROBE_SAMPLE_COUNT)
                2'b01: VOTE_SAMPLES <= ptc_pkg::VOTE_N_SHORT;
                2'b10: VOTE_SAMPLES <= ptc_pkg::VOTE_N_LONG;
                default: VOTE_SAMPLES <= ptc_pkg::VOTE_N_DEFAULT;
            endcase
            DYN_TX_ENABLE <= (LATEST_DYNAMIC_TX_MINISLOT != 13'h0000);
            STATIC_PAYLOAD_BYTES <= {STATIC_PAYLOAD_WORDS, 1'b0};
        end
    end

    // Cycle position strobes, one cycle after the matching macrotick
    always_ff @(posedge CLK) begin
        if (RST) begin
            IDLE_TIME_START <= 1'b0;
            OFFSET_CORR_START <= 1'b0;
        end else begin
            IDLE_TIME_START <= MT_TICK && (MT_COUNT == IDLE_TIME_BEGIN);
            OFFSET_CORR_START <= MT_TICK && (MT_COUNT == ocs_pos);
        end
    end

    // Bit decoder; settings change only while configuring, so no resync needed
    ptc_bit_voter u_voter (
        .clk(CLK),
        .rst(RST),
        .sclk_en(SCLK_EN),
        .period_sel(BAUD_PRESCALE_SEL),
        .strobe_sel(STROBE_SAMPLE_COUNT),
        .rx_line(RX_LINE),
        .bit_r(RX_BIT),
        .bit_valid_r(RX_BIT_VALID)
    );

    AST_LOCKED_NO_CHANGE: assert property (@(posedge CLK) disable iff (RST)
        wr_commit && !cfg_open |=> cfg_q[0] == $past(cfg_q[0]) && cfg_q[1] == $past(cfg_q[1])
        && cfg_q[6] == $past(cfg_q[6]))
        else $error("configuration changed outside configuration state");
    AST_OPEN_WRITE_LANDS: assert property (@(posedge CLK) disable iff (RST)
        wr_commit && cfg_open && addr_ok && idx == 3'h4
        |=> cfg_q[4] == ($past(PWDATA) & ptc_pkg::REG_MASK[4]))
        else $error("write in configuration state not stored");
    AST_CASM_TOP_ONE: assert property (@(posedge CLK) disable iff (RST)
        ##1 COLLISION_SYMBOL_MAX[6])
        else $error("collision symbol limit top bit not one");
    AST_PAYLOAD_TWICE: assert property (@(posedge CLK) disable iff (RST)
        ##1 STATIC_PAYLOAD_BYTES == {$past(STATIC_PAYLOAD_WORDS), 1'b0})
        else $error("static payload bytes not twice the field");
    AST_DYN_ZERO_OFF: assert property (@(posedge CLK) disable iff (RST)
        LATEST_DYNAMIC_TX_MINISLOT == 13'h0000 |=> !DYN_TX_ENABLE)
        else $error("dynamic sending enabled with zero limit");
    AST_PRESCALE_FOUR: assert property (@(posedge CLK) disable iff (RST)
        BAUD_PRESCALE_SEL[1] |=> SAMPLE_PERIOD == 3'h4 && SAMPLES_PER_MICROTICK == 2'h1)
        else $error("prescaler decode wrong");
    AST_VOTE_FOUR: assert property (@(posedge CLK) disable iff (RST)
        STROBE_SAMPLE_COUNT == 2'b01 |=> VOTE_SAMPLES == 3'h4)
        else $error("vote width wrong for code one");
    AST_IDLE_START: assert property (@(posedge CLK) disable iff (RST)
        MT_TICK && MT_COUNT == IDLE_TIME_BEGIN |=> IDLE_TIME_START)
        else $error("idle time start strobe missing");
    // Without a macrotick there is nothing to match, so the strobe stays low
    AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (RST)
        !MT_TICK |=> !IDLE_TIME_START)
        else $error("idle time start strobe without macrotick");
    AST_READ_BACK: assert property (@(posedge CLK) disable iff (RST)
        access_start && !PWRITE && addr_ok && idx == 3'h6
        |=> PREADY && PRDATA == $past(cfg_q[6]))
        else $error("read data does not match stored word");
    AST_ONE_WAIT: assert property (@(posedge CLK) disable iff (RST)
        access_start |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after one wait");
endmodule : ptc_timing_bank

// ---- test/ptc_testbench.sv ----
// Self-checking bench for the protocol timing configuration bank
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x;} ptc_row_s;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic pready, pslverr, sclk_en = 1'b1, rx_line = 1'b1, mt_tick = 1'b0;
    logic [3:0] poc = 4'h1;
    logic [13:0] mt_count = 14'h0000;
    logic [5:0] rpt, txl, rxl, rxi;
    logic [8:0] rxwin;
    logic [1:0] brp, spp, spm;
    logic [6:0] casm, sfdl, miob, mioa;
    logic [3:0] tss, snm;
    logic [7:0] txi, uiob, uioa, pbytes;
    logic [12:0] slt;
    logic [19:0] ut;
    logic [13:0] mpc, ocsf, nitf;
    logic [2:0] per, vote;
    logic dyn, idle, ocs, rx_bit, rx_valid;
    int n_mismatch = 0, samples_checked = 0;
    // Ordinary writes: address, data, expected read back
    ptc_row_s rows [0:15] = '{
        '{8'h00, 32'hffffffff, 32'hfdfff7ff}, '{8'h00, 32'h00000000, 32'h00000400},
        '{8'h00, 32'hfd2d6633, 32'hfd2d6633}, '{8'h04, 32'hffffffff, 32'h3fff3f3f},
        '{8'h04, 32'h3cb4373b, 32'h3cb4373b}, '{8'h08, 32'hffffffff, 32'h1fff007f},
        '{8'h08, 32'h1f2d007f, 32'h1f2d007f}, '{8'h0c, 32'hffffffff, 32'h000fffff},
        '{8'h0c, 32'h0009c400, 32'h0009c400}, '{8'h10, 32'hffffffff, 32'h000f3fff},
        '{8'h10, 32'h000f3e80, 32'h000f3e80}, '{8'h14, 32'hffffffff, 32'h7f7fffff},
        '{8'h14, 32'h4802f000, 32'h4802f000}, '{8'h18, 32'hffffffff, 32'h3fff3fff},
        '{8'h18, 32'h0014001e, 32'h0014001e}, '{8'h0c, 32'h00000280, 32'h00000280}};

    ptc_timing_bank dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .POC_STATE(poc), .SCLK_EN(sclk_en), .RX_LINE(rx_line),
        .MT_TICK(mt_tick), .MT_COUNT(mt_count), .WAKEUP_REPEAT_COUNT(rpt),
        .WAKEUP_RX_WINDOW(rxwin), .BAUD_PRESCALE_SEL(brp), .STROBE_SAMPLE_COUNT(spp),
        .COLLISION_SYMBOL_MAX(casm), .START_SEQUENCE_LENGTH(tss), .WAKEUP_TX_LOW_TIME(txl),
        .WAKEUP_TX_IDLE_TIME(txi), .WAKEUP_RX_LOW_TIME(rxl), .WAKEUP_RX_IDLE_TIME(rxi),
        .LATEST_DYNAMIC_TX_MINISLOT(slt), .STATIC_PAYLOAD_WORDS(sfdl),
        .CYCLE_MICROTICK_TOTAL(ut), .SYNC_SENDER_LIMIT(snm), .CYCLE_MACROTICK_TOTAL(mpc),
        .MACRO_INITIAL_OFFSET_B(miob), .MACRO_INITIAL_OFFSET_A(mioa),
        .MICRO_INITIAL_OFFSET_B(uiob), .MICRO_INITIAL_OFFSET_A(uioa),
        .OFFSET_CORRECTION_BEGIN(ocsf), .IDLE_TIME_BEGIN(nitf), .SAMPLE_PERIOD(per),
        .SAMPLES_PER_MICROTICK(spm), .VOTE_SAMPLES(vote), .DYN_TX_ENABLE(dyn),
        .STATIC_PAYLOAD_BYTES(pbytes), .IDLE_TIME_START(idle), .OFFSET_CORR_START(ocs),
        .RX_BIT(rx_bit), .RX_BIT_VALID(rx_valid));

    // 25 MHz clock
    always #20 clk = ~clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready, data and error taken at the rising edge; the watchdog bounds a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk(32'(e), 32'(ee));
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h00000000, q, e);
        chk(q, x);
        chk(32'(e), 32'(ee));
    endtask : rd

    // Line held steady; gap between decided bits must match the prescaler
    task dec(input logic [1:0] ps, input logic ln, input int gap);
        int n;
        wr(8'h00, {16'h0000, ps, 14'h0400}, 1'b0);
        rx_line <= ln;
        for (int p = 0; p < 3; p++) begin
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (rx_valid !== 1'b1 && n < 100);
        end
        chk(32'(n), 32'(gap));
        chk(32'(rx_bit), 32'(ln));
    endtask : dec

    task mt(input logic [13:0] c, input logic ei, input logic eo);
        @(posedge clk);
        mt_count <= c;
        mt_tick <= 1'b1;
        @(posedge clk);
        mt_tick <= 1'b0;
        @(negedge clk);
        chk(32'(idle), 32'(ei));
        chk(32'(ocs), 32'(eo));
    endtask : mt

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // Watchdog sized well beyond the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, 1'b0);
            rd(rows[i].a, rows[i].x, 1'b0);
        end
        chk({26'h0, rpt}, 32'd63);
        chk({23'h0, rxwin}, 32'd301);
        chk({25'h0, casm}, 32'd99);
        chk({24'h0, brp, spp, tss}, {24'h0, 2'b01, 2'b10, 4'd3});
        chk({txl, txi, rxl, rxi}, {6'd60, 8'd180, 6'd55, 6'd59});
        chk({snm, mpc, ocsf}, {4'd15, 14'd16000, 14'd20});
        chk({miob, mioa, uiob, uioa}, {7'd72, 7'd2, 8'd240, 8'd0});
        chk({12'h0, ut}, 32'd640);
        chk({slt, pbytes, dyn, sfdl}, {13'd7981, 8'd254, 1'b1, 7'd127});
        $display("test table done");
        wr(8'h08, 32'h00000005, 1'b0);
        repeat (2) @(negedge clk);
        chk({pbytes, 7'h0, dyn}, {8'd10, 8'h00});
        @(posedge clk);
        poc <= 4'h5;
        wr(8'h04, 32'h00000000, 1'b1);
        rd(8'h04, 32'h3cb4373b, 1'b0);
        rd(8'h1c, 32'h00000002, 1'b0);
        chk({26'h0, txl}, 32'd60);
        poc <= 4'h0;
        wr(8'h04, 32'h00000000, 1'b0);
        rd(8'h04, 32'h00000000, 1'b0);
        wr(8'h1c, 32'h00000002, 1'b0);
        rd(8'h1c, 32'h00000001, 1'b0);
        rd(8'h20, 32'h00000000, 1'b1);
        rd(8'h02, 32'h00000000, 1'b1);
        $display("test lock done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, {16'h0000, c[1:0], c[1:0], 12'h400}, 1'b0);
            repeat (2) @(negedge clk);
            chk({29'h0, per}, (c == 0) ? 32'd1 : (c == 1) ? 32'd2 : 32'd4);
            chk({30'h0, spm}, (c == 0) ? 32'd2 : 32'd1);
            chk({29'h0, vote}, (c == 1) ? 32'd4 : (c == 2) ? 32'd6 : 32'd5);
        end
        dec(2'b00, 1'b0, 8);
        dec(2'b01, 1'b1, 16);
        dec(2'b10, 1'b0, 32);
        $display("test decoder done");
        mt(14'd30, 1'b1, 1'b0);
        mt(14'd21, 1'b0, 1'b1);
        mt(14'd20, 1'b0, 1'b0);
        $display("test macrotick done");
        // Second reset mid-run: defaults come back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h00000400, 1'b0);
        rd(8'h10, 32'h00000002, 1'b0);
        rd(8'h14, 32'h00000002, 1'b0);
        rd(8'h18, 32'h00000000, 1'b0);
        chk({per, spm, vote, dyn}, {3'd1, 2'd2, 3'd5, 1'b0});
        $display("test reset done");
        wrap_up;
    end
endmodule : testbench
